// ### verif/plc_host_model.sv
// Host model: classic single-cycle bus master issuing commands
`timescale 1ns/100ps
module plc_host_model (
  input  wire logic        clk_in,
  input  wire logic        ack_in,
  output logic      [7:0]  adr_out,
  output logic      [31:0] dat_out,
  output logic             we_out,
  output logic             cyc_out,
  output logic             stb_out
);
  // ==========================================================================
  // Bus cycle
  initial begin
    adr_out = 8'h00;
    dat_out = 32'h0000_0000;
    we_out  = 1'b0;
    cyc_out = 1'b0;
    stb_out = 1'b0;
  end
  // Held until ack is sampled; one idle cycle follows each request
  task automatic xfer(input logic [7:0] a, input logic [31:0] d, input logic w);
    @(posedge clk_in);
    adr_out <= a;
    dat_out <= d;
    we_out  <= w;
    cyc_out <= 1'b1;
    stb_out <= 1'b1;
    do @(posedge clk_in); while (ack_in !== 1'b1);
    cyc_out <= 1'b0;
    stb_out <= 1'b0;
    we_out  <= 1'b0;
  endtask : xfer
endmodule : plc_host_model

// ### verif/sync_cmd_sva.sv
// Port assertions for the sync/override command checker
`timescale 1ns/100ps
module sync_cmd_sva
  import sync_cmd_pkg::*;
(
  input wire logic        clk_in,
  input wire logic        reset_n_in,
  input wire logic [7:0]  wb_adr_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic [3:0]  wb_sel_in,
  input wire logic        wb_we_in,
  input wire logic        wb_cyc_in,
  input wire logic        wb_stb_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic        wb_ack_out,
  input wire logic        cmd_accept_out,
  input wire logic [3:0]  cmd_code_out,
  input wire logic        cmd_axis_out,
  input wire logic        cmd_main_out
);
  // ==========================================================================
  // Sequences and properties
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  sequence s_req;
    wb_cyc_in && wb_stb_in && !wb_ack_out;
  endsequence
  sequence s_cmd;
    s_req ##0 (wb_we_in && wb_adr_in == ADDR_CMD && wb_sel_in[0]);
  endsequence
  a_ack_answer: assert property (s_req |=> wb_ack_out)
    else $error("ack missing");
  a_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack too long");
  a_ack_cause: assert property ($rose(wb_ack_out)
    |-> $past(wb_cyc_in && wb_stb_in))
    else $error("ack without request");
  a_rd_idle: assert property (!wb_ack_out |-> wb_dat_out == 32'h0000_0000)
    else $error("read data outside ack");
  a_accept_ack: assert property (cmd_accept_out |-> wb_ack_out)
    else $error("accept outside ack");
  a_accept_cause: assert property (cmd_accept_out
    |-> $past(wb_we_in && wb_adr_in == ADDR_CMD))
    else $error("accept without command write");
  a_cmd_latch: assert property (s_cmd |=> cmd_code_out == $past(wb_dat_in[3:0])
    && cmd_axis_out == $past(wb_dat_in[4]) && cmd_main_out == $past(wb_dat_in[5]))
    else $error("command not latched");
  a_ps_axes: assert property (cmd_accept_out
    && cmd_code_out == CMD_POS_SYNC |-> cmd_main_out != cmd_axis_out)
    else $error("pos sync same axes accepted");
  a_ss_axes: assert property (cmd_accept_out
    && cmd_code_out == CMD_SPD_SYNC |-> cmd_main_out != cmd_axis_out)
    else $error("speed sync same axes accepted");
endmodule : sync_cmd_sva

bind sync_override_command_checker sync_cmd_sva u_sva (
  .clk_in(clk_in), .reset_n_in(reset_n_in), .wb_adr_in(wb_adr_in),
  .wb_dat_in(wb_dat_in), .wb_sel_in(wb_sel_in), .wb_we_in(wb_we_in),
  .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_dat_out(wb_dat_out),
  .wb_ack_out(wb_ack_out), .cmd_accept_out(cmd_accept_out),
  .cmd_code_out(cmd_code_out), .cmd_axis_out(cmd_axis_out),
  .cmd_main_out(cmd_main_out)
);

// ### verif/sync_override_command_checker_test.sv
// Self-checking bench for the sync/override command checker
`timescale 1ns/100ps
module sync_override_command_checker_test
  import sync_cmd_pkg::*;
  ;
  logic        clk_in, reset_n_in, we, cyc, stb, ack, acc;
  logic [7:0]  adr, ea;
  logic [31:0] wdat, rdat, r;
  logic [32:0] q[$], exp_v;
  logic [47:0] t;
  int          n_mismatch = 0, checks_done = 0, cycles = 0, seed;
  // Case: sub ratio, command, status X, status Y, expected error
  logic [47:0] tbl [26] = '{
    48'h1_21_002_000_142, 48'h1_21_001_000_000,
    48'h1_22_001_000_155, 48'h1_22_000_000_000,
    48'h1_23_014_010_156, 48'h1_23_018_010_157,
    48'h1_63_000_010_158, 48'h1_03_010_010_15B,
    48'h1_23_010_000_15A, 48'h1_23_010_210_15D,
    48'h1_63_010_010_000, 48'h1_24_001_000_15F,
    48'h1_24_004_000_160, 48'h1_24_008_000_161,
    48'h1_04_000_000_163, 48'h1_24_000_001_15E,
    48'h0_24_000_000_164, 48'h2_24_000_000_000,
    48'h3_24_000_000_165, 48'h1_25_000_000_169,
    48'h1_25_061_000_16A, 48'h1_25_0C1_000_16C,
    48'h1_25_141_000_16D, 48'h1_25_001_000_16B,
    48'h1_11_000_002_142, 48'h1_25_041_000_000
  };
  sync_override_command_checker dut (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .wb_adr_in(adr), .wb_dat_in(wdat), .wb_sel_in(4'hF), .wb_we_in(we),
    .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_dat_out(rdat), .wb_ack_out(ack),
    .cmd_accept_out(acc), .cmd_code_out(), .cmd_axis_out(), .cmd_main_out());
  plc_host_model host (.clk_in(clk_in), .ack_in(ack), .adr_out(adr),
    .dat_out(wdat), .we_out(we), .cyc_out(cyc), .stb_out(stb));
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  // ==========================================================================
  // Drivers, monitor, verdict
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic c);
    q.push_back({c, 32'h0000_0000});
    host.xfer(a, d, 1'b1);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    q.push_back({1'b0, e});
    host.xfer(a, 32'h0000_0000, 1'b0);
  endtask : rd
  task close_out;
    $display("Mismatches %0d, checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out
  always @(posedge clk_in) begin
    if (reset_n_in === 1'b1 && ack === 1'b1) begin
      exp_v = (q.size() != 0) ? q.pop_front() : 'x;
      checks_done++;
      if ({acc, rdat} !== exp_v) begin
        n_mismatch++;
        $display("Error at %0t: got %h want %h", $time, {acc, rdat}, exp_v);
      end
    end
  end
  // Generous ceiling; the sequence needs a few hundred cycles
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      close_out();
    end
  end
  initial begin
    seed = 32'h1EB3;
    reset_n_in = 1'b0;
    repeat (8) @(posedge clk_in);
    reset_n_in <= 1'b1;
    rd(ADDR_SPDLIM, SPDLIM_RST);
    rd(ADDR_PARAM, {RATIO_RST, RATIO_RST});
    rd(ADDR_ERR_X, 32'h0000_0000);
    wr(8'h24, 32'hFFFF_FFFF, 1'b0);
    rd(8'h24, 32'h0000_0000);
    repeat (4) begin
      r = $random(seed) & 32'h0000_FFFF;
      wr(ADDR_MAINSPD, r, 1'b0);
      rd(ADDR_MAINSPD, r);
    end
    wr(ADDR_SPDLIM, 32'h0000_00C8, 1'b0);
    wr(ADDR_MAINSPD, 32'h0000_0064, 1'b0);
    foreach (tbl[i]) begin
      t = tbl[i];
      ea = t[40] ? ADDR_ERR_Y : ADDR_ERR_X;
      wr(ADDR_PARAM, {12'h000, t[47:44], 16'h0001}, 1'b0);
      wr(ADDR_STAT_X, {20'h00000, t[35:24]}, 1'b0);
      wr(ADDR_STAT_Y, {20'h00000, t[23:12]}, 1'b0);
      wr(ea, 32'h0000_0000, 1'b0);
      wr(ADDR_CMD, {24'h000000, t[43:36]}, t[11:0] == 12'h000);
      rd(ea, {20'h00000, t[11:0]});
      rd(ADDR_STAT_X, {20'h00000, t[35:24]});
      rd(ADDR_RESULT, {30'h0, 1'b1, t[11:0] == 12'h000});
    end
    wr(ADDR_STAT_X, 32'h0000_0018, 1'b0);
    wr(ADDR_STAT_Y, 32'h0000_0010, 1'b0);
    wr(ADDR_CMD, 32'h0000_0026, 1'b1);
    rd(ADDR_STAT_X, 32'h0000_0010);
    wr(ADDR_CMD, 32'h0000_0023, 1'b1);
    rd(ADDR_RESULT, 32'h0000_0003);
    wr(ADDR_CMD, 32'h0000_0007, 1'b1);
    rd(ADDR_ERR_X, 32'h0000_0000);
    repeat (2) @(posedge clk_in);
    close_out();
  end
endmodule : sync_override_command_checker_test

// ### verilog/sync_cmd_pkg.sv
// Package of constants and types for the sync/override command checker
// Summary of operation
// [R1] Deceleration stop refused on an axis in jog; error 322.
// [R2] Sync start by position refused when commanded axis is busy; error 341.
// [R3] Position sync refused while axis output is inhibited; error 342.
// [R4] Position sync refused while aux-code flag set; error 343; aux-off clears.
// [R5] Position sync absolute step refused with origin undetermined; error 344.
// [R6] Position sync refused when main axis origin undetermined; error 346.
// [R7] Main axis 0 is X, 1 is Y; equal to commanded axis gives 347.
// [R8] Position sync refused when main axis already a position-sync sub; 349.
// [R9] Speed sync refused while main axis moves; error 350.
// [R10] Speed sync refused when commanded axis busy; error 351.
// [R11] Speed sync refused while axis output inhibited; error 352.
// [R12] Speed sync refused while aux-code flag set; error 353.
// [R13] Speed sync main axis equal to commanded axis gives error 355.
// [R14] Speed sync refused when either ratio is zero; error 356.
// [R15] Speed sync refused when ratio-derived speed exceeds limit; error 357.
// [R16] Position override refused on a stopped axis; error 361.
// [R17] Position override refused during dwell; error 362.
// [R18] Position override refused outside positioning control; error 363.
// [R19] Position override refused during linear interpolation; error 364.
// [R20] Position override refused during circular interpolation; error 365.
// [R21] On failure, command discarded, motion unchanged, error readable per axis.
package sync_cmd_pkg;

  // ==========================================================================
  // Register map (byte addresses)
  localparam logic [7:0] ADDR_CMD      = 8'h00;
  localparam logic [7:0] ADDR_PARAM    = 8'h04;
  localparam logic [7:0] ADDR_STAT_X   = 8'h08;
  localparam logic [7:0] ADDR_STAT_Y   = 8'h0C;
  localparam logic [7:0] ADDR_ERR_X    = 8'h10;
  localparam logic [7:0] ADDR_ERR_Y    = 8'h14;
  localparam logic [7:0] ADDR_SPDLIM   = 8'h18;
  localparam logic [7:0] ADDR_MAINSPD  = 8'h1C;
  localparam logic [7:0] ADDR_RESULT   = 8'h20;

  // ==========================================================================
  // Command and parameter register fields
  localparam int CMD_CODE_LSB  = 0;
  localparam int CMD_AXIS_BIT  = 4;
  localparam int CMD_MAIN_BIT  = 5;
  localparam int CMD_ABS_BIT   = 6;
  localparam int PARAM_MRAT_LSB = 0;
  localparam int PARAM_SRAT_LSB = 16;

  typedef enum logic [3:0] {
    CMD_NONE       = 4'h0,
    CMD_DEC_STOP   = 4'h1,
    CMD_SYNC_POS   = 4'h2,
    CMD_POS_SYNC   = 4'h3,
    CMD_SPD_SYNC   = 4'h4,
    CMD_POS_OVR    = 4'h5,
    CMD_AUX_OFF    = 4'h6,
    CMD_ABORT      = 4'h7
  } cmd_e;

  // ==========================================================================
  // Axis status register fields
  localparam int ST_BUSY    = 0;
  localparam int ST_JOG     = 1;
  localparam int ST_INHIBIT = 2;
  localparam int ST_AUX     = 3;
  localparam int ST_ORIGIN  = 4;
  localparam int ST_DWELL   = 5;
  localparam int ST_POSCTL  = 6;
  localparam int ST_LININT  = 7;
  localparam int ST_CIRINT  = 8;
  localparam int ST_PSSUB   = 9;
  localparam int ST_SSSUB   = 10;
  localparam int ST_WIDTH   = 11;

  typedef struct packed {
    logic cir_interp;
    logic lin_interp;
    logic pos_ctl;
    logic dwell;
    logic origin_ok;
    logic aux_flag;
    logic inhibit;
    logic jog;
    logic busy;
  } axis_stat_s;

  typedef struct packed {
    logic        ss_sub;
    logic        ps_sub;
    axis_stat_s  st;
  } axis_full_s;

  // ==========================================================================
  // Error codes
  localparam logic [9:0] ERR_NONE      = 10'd0;
  localparam logic [9:0] ERR_DEC_JOG   = 10'd322;
  localparam logic [9:0] ERR_SP_BUSY   = 10'd341;
  localparam logic [9:0] ERR_PS_INH    = 10'd342;
  localparam logic [9:0] ERR_PS_AUX    = 10'd343;
  localparam logic [9:0] ERR_PS_ORG    = 10'd344;
  localparam logic [9:0] ERR_PS_MORG   = 10'd346;
  localparam logic [9:0] ERR_PS_AXIS   = 10'd347;
  localparam logic [9:0] ERR_PS_MSUB   = 10'd349;
  localparam logic [9:0] ERR_SS_MBUSY  = 10'd350;
  localparam logic [9:0] ERR_SS_BUSY   = 10'd351;
  localparam logic [9:0] ERR_SS_INH    = 10'd352;
  localparam logic [9:0] ERR_SS_AUX    = 10'd353;
  localparam logic [9:0] ERR_SS_AXIS   = 10'd355;
  localparam logic [9:0] ERR_SS_RATIO  = 10'd356;
  localparam logic [9:0] ERR_SS_LIMIT  = 10'd357;
  localparam logic [9:0] ERR_PO_STOP   = 10'd361;
  localparam logic [9:0] ERR_PO_DWELL  = 10'd362;
  localparam logic [9:0] ERR_PO_CTL    = 10'd363;
  localparam logic [9:0] ERR_PO_LIN    = 10'd364;
  localparam logic [9:0] ERR_PO_CIR    = 10'd365;

  // ==========================================================================
  // Reset values
  localparam logic [31:0] SPDLIM_RST   = 32'h0000_FFFF;
  localparam logic [15:0] RATIO_RST    = 16'h0001;

endpackage : sync_cmd_pkg

// ### verilog/sync_override_command_checker.sv
// Command checker for sync, override and stop commands of a two-axis unit
//
// Chosen here: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/100ps
module sync_override_command_checker
  import sync_cmd_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        reset_n_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [31:0] wb_dat_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic        wb_we_in,
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  output logic      [31:0] wb_dat_out,
  output logic             wb_ack_out,
  output logic             cmd_accept_out,
  output logic      [3:0]  cmd_code_out,
  output logic             cmd_axis_out,
  output logic             cmd_main_out
);

  // ==========================================================================
  // Registers
  axis_full_s  stat_r [2];
  logic [9:0]  err_r [2];
  logic [15:0] mratio_r;
  logic [15:0] sratio_r;
  logic [31:0] spdlim_r;
  logic [31:0] mainspd_r;
  logic [1:0]  result_r;
  logic        acc_nxt;
  logic [9:0]  err_nxt;

  logic        req;
  logic        wr_cmd;
  logic [3:0]  code;
  logic        ax;
  logic        mn;
  logic        absol;
  axis_full_s  a;
  axis_full_s  m;
  logic [47:0] derived;

  assign req    = wb_cyc_in & wb_stb_in & ~wb_ack_out;
  assign wr_cmd = req & wb_we_in & (wb_adr_in == ADDR_CMD) & wb_sel_in[0];
  assign code   = wb_dat_in[CMD_CODE_LSB +: 4];
  assign ax     = wb_dat_in[CMD_AXIS_BIT];
  assign mn     = wb_dat_in[CMD_MAIN_BIT];
  assign absol  = wb_dat_in[CMD_ABS_BIT];
  assign a      = stat_r[ax];
  assign m      = stat_r[mn];
  // Main axis speed scaled by sub/main ratio; wide to avoid overflow
  assign derived = (mratio_r == 16'h0000) ? 48'h0 :
                   48'((64'(mainspd_r) * 64'(sratio_r)) / 64'(mratio_r));

  // ==========================================================================
  // Command checks, first failing check wins
  always_comb begin
    err_nxt = ERR_NONE;
    unique case (code)
      CMD_DEC_STOP: begin
        if (a.st.jog) err_nxt = ERR_DEC_JOG; // [R1]
      end
      CMD_SYNC_POS: begin
        if (a.st.busy) err_nxt = ERR_SP_BUSY; // [R2]
      end
      CMD_POS_SYNC: begin
        if (a.st.inhibit) err_nxt = ERR_PS_INH; // [R3]
        else if (a.st.aux_flag) err_nxt = ERR_PS_AUX; // [R4]
        else if (absol && !a.st.origin_ok) err_nxt = ERR_PS_ORG; // [R5]
        else if (mn == ax) err_nxt = ERR_PS_AXIS; // [R7]
        else if (!m.st.origin_ok) err_nxt = ERR_PS_MORG; // [R6]
        else if (m.ps_sub) err_nxt = ERR_PS_MSUB; // [R8]
      end
      CMD_SPD_SYNC: begin
        if (a.st.busy) err_nxt = ERR_SS_BUSY; // [R10]
        else if (a.st.inhibit) err_nxt = ERR_SS_INH; // [R11]
        else if (a.st.aux_flag) err_nxt = ERR_SS_AUX; // [R12]
        else if (mn == ax) err_nxt = ERR_SS_AXIS; // [R13]
        else if (m.st.busy) err_nxt = ERR_SS_MBUSY; // [R9]
        else if (mratio_r == 16'h0000 || sratio_r == 16'h0000)
          err_nxt = ERR_SS_RATIO; // [R14]
        else if (derived > 48'(spdlim_r)) err_nxt = ERR_SS_LIMIT; // [R15]
      end
      CMD_POS_OVR: begin
        if (!a.st.busy) err_nxt = ERR_PO_STOP; // [R16]
        else if (a.st.dwell) err_nxt = ERR_PO_DWELL; // [R17]
        else if (a.st.lin_interp) err_nxt = ERR_PO_LIN; // [R19]
        else if (a.st.cir_interp) err_nxt = ERR_PO_CIR; // [R20]
        else if (!a.st.pos_ctl) err_nxt = ERR_PO_CTL; // [R18]
      end
      default: err_nxt = ERR_NONE;
    endcase
    acc_nxt = (err_nxt == ERR_NONE);
  end

  // ==========================================================================
  // Accepted command pulse toward the motion engine
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      cmd_accept_out <= 1'b0;
      cmd_code_out   <= 4'h0;
      cmd_axis_out   <= 1'b0;
      cmd_main_out   <= 1'b0;
    end else begin
      // Refused commands never reach the engine
      cmd_accept_out <= wr_cmd & acc_nxt & (code != CMD_NONE); // [R21]
      if (wr_cmd) begin
        cmd_code_out <= code;
        cmd_axis_out <= ax;
        cmd_main_out <= mn;
      end
    end
  end

  // ==========================================================================
  // Per-axis error codes and last result
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      err_r[0] <= ERR_NONE;
      err_r[1] <= ERR_NONE;
      result_r <= 2'b00;
    end else if (wr_cmd && code != CMD_NONE) begin
      result_r <= {1'b1, acc_nxt};
      if (!acc_nxt) err_r[ax] <= err_nxt; // [R21]
    end else if (req && wb_we_in && wb_adr_in == ADDR_ERR_X) begin
      err_r[0] <= ERR_NONE;
    end else if (req && wb_we_in && wb_adr_in == ADDR_ERR_Y) begin
      err_r[1] <= ERR_NONE;
    end
  end

  // ==========================================================================
  // Axis state, ratios, limits
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      stat_r[0] <= '0;
      stat_r[1] <= '0;
      mratio_r  <= RATIO_RST;
      sratio_r  <= RATIO_RST;
      spdlim_r  <= SPDLIM_RST;
      mainspd_r <= 32'h0000_0000;
    end else if (wr_cmd && code == CMD_AUX_OFF) begin
      stat_r[ax].st.aux_flag <= 1'b0; // [R4]
    end else if (req && wb_we_in) begin
      unique case (wb_adr_in)
        ADDR_STAT_X: stat_r[0] <= wb_dat_in[ST_WIDTH-1:0];
        ADDR_STAT_Y: stat_r[1] <= wb_dat_in[ST_WIDTH-1:0];
        ADDR_PARAM: begin
          mratio_r <= wb_dat_in[PARAM_MRAT_LSB +: 16];
          sratio_r <= wb_dat_in[PARAM_SRAT_LSB +: 16];
        end
        ADDR_SPDLIM:  spdlim_r  <= wb_dat_in;
        ADDR_MAINSPD: mainspd_r <= wb_dat_in;
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // Wishbone answer, one cycle after request
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
    end else begin
      wb_ack_out <= req;
      wb_dat_out <= 32'h0000_0000;
      if (req && !wb_we_in) begin
        unique case (wb_adr_in)
          ADDR_PARAM:   wb_dat_out <= {sratio_r, mratio_r};
          ADDR_STAT_X:  wb_dat_out <= {21'h0, stat_r[0]};
          ADDR_STAT_Y:  wb_dat_out <= {21'h0, stat_r[1]};
          ADDR_ERR_X:   wb_dat_out <= {22'h0, err_r[0]};
          ADDR_ERR_Y:   wb_dat_out <= {22'h0, err_r[1]};
          ADDR_SPDLIM:  wb_dat_out <= spdlim_r;
          ADDR_MAINSPD: wb_dat_out <= mainspd_r;
          ADDR_RESULT:  wb_dat_out <= {30'h0, result_r};
          default:      wb_dat_out <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule : sync_override_command_checker
